/* swt_checker.sv */
// Port assertions for the self wake-up timer.
// Bound to the timer from the bench; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module swt_checker (
  input wire logic i_mclk,
  input wire logic i_resetn,
  input wire logic i_ce,
  input wire logic [7:0] i_addr,
  input wire logic [31:0] i_wdata,
  input wire logic i_wr,
  input wire logic i_rd,
  input wire logic [31:0] o_rdata,
  input wire logic o_irq,
  input wire logic o_wake_req,
  input wire logic o_running
);
  // ************************************************************
  // Properties
  // ************************************************************
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_resetn);
  wire c_wr = i_ce && i_wr && i_addr == 8'h00;
  wire cnt_wr = i_ce && i_wr && i_addr == 8'h0c;
  wire s_wr = i_ce && i_wr && i_addr == 8'h10;
  wire w1c = (c_wr || s_wr) && i_wdata[1];
  wire clr = c_wr && i_wdata[2];
  sequence s_start; cnt_wr && i_wdata > 32'h1; endsequence
  sequence s_clear; clr; endsequence
  a_clear_reads_zero: assert property (i_ce && i_rd && i_addr == 8'h00
    |=> o_rdata[31:2] == 30'h0) else $error("clear bit read back set");
  a_count_starts: assert property (s_start |=> ##1 o_running)
    else $error("count write did not start");
  a_clear_halts: assert property (s_clear |=> ##1 !o_running)
    else $error("clear did not halt");
  a_irq_needs_alarm: assert property (o_irq |-> o_wake_req)
    else $error("irq without alarm");
  a_alarm_sticky: assert property (o_wake_req && !w1c && !$past(w1c)
    |=> o_wake_req) else $error("alarm dropped by itself");
  a_alarm_clears: assert property (w1c && o_wake_req && !o_running
    && !$past(cnt_wr) |=> ##1 !o_wake_req) else $error("alarm not cleared");
  a_timeout_alarm: assert property ($fell(o_running) && !$past(clr, 2)
    |-> o_wake_req) else $error("stop without alarm");
  a_no_reload: assert property (!o_running && !$past(cnt_wr)
    |=> !o_running) else $error("counter restarted alone");
endmodule
`default_nettype wire

/* swt_defines.vh */
// Constants for the self wake-up down-counter: offsets, fields, resets,
// and the timer tick rates. Included by the timer module only.
`ifndef SWT_DEFINES_VH
`define SWT_DEFINES_VH

// ************************************************************
// Register offsets (byte addresses)
// ************************************************************
`define SWT_OFS_CTRL 8'h00
`define SWT_OFS_COUNT 8'h0c
`define SWT_OFS_IRQ_STAT 8'h10
`define SWT_OFS_IRQ_MASK 8'h14

// ************************************************************
// Control register fields and reset values
// ************************************************************
`define SWT_CTRL_TIMER_CLOCK_SELECT 0
`define SWT_CTRL_ALARM 1
`define SWT_CTRL_CLEAR 2
`define SWT_CTRL_RESET 32'h00000000
`define SWT_TIMER_CLOCK_SELECT_RESET 1'b0
`define SWT_MASK_RESET 1'b0
`define SWT_COUNT_RESET 32'h00000000

// ************************************************************
// Timing: tick source rates and system clock, all in Hz
// ************************************************************
`define SWT_MCLK_HZ 25000000
`define SWT_RC_TICK_HZ 750000
`define SWT_LP_TICK_HZ 10000

`endif

/* swt_self_wake_timer.v */
// Self wake-up timer: 32-bit down-counter with selectable tick source,
// sticky alarm flag, interrupt status/mask and a wake request output.
// Assumes a simple register port, synchronous inputs and one clock; the
// two tick sources are modelled as rate accumulators on that clock.
//
// Local design decision: the strobed register port.
`timescale 1ns/1ns
`default_nettype none
`include "swt_defines.vh"

module swt_self_wake_timer #(
  parameter integer MCLK_HZ = `SWT_MCLK_HZ,
  parameter integer RC_TICK_HZ = `SWT_RC_TICK_HZ,
  parameter integer LP_TICK_HZ = `SWT_LP_TICK_HZ
) (
  input wire i_mclk,
  input wire i_resetn,
  input wire i_ce,
  input wire [7:0] i_addr,
  input wire [31:0] i_wdata,
  input wire i_wr,
  input wire i_rd,
  output reg [31:0] o_rdata,
  output reg o_irq,
  output reg o_wake_req,
  output reg o_running
);

  // ************************************************************
  // Local constants
  // ************************************************************
  localparam integer NUM_SRC = 2;
  localparam integer SRC_RC = 0;
  localparam integer SRC_LP = 1;
  localparam [31:0] MCLK_RATE = MCLK_HZ;
  localparam [0:0] ST_IDLE = 1'b0;
  localparam [0:0] ST_RUN = 1'b1;
  localparam [31:0] CNT_ZERO = 32'h00000000;
  localparam [31:0] CNT_ONE = 32'h00000001;

  // ************************************************************
  // Tick generation
  // ************************************************************
  // Each source is a phase accumulator on the system clock, so the
  // average tick rate is exact even where the ratio is not whole.
  // Limitation: a tick rate must not exceed the system clock rate.
  // Both run all the time; a source switch does not restart a phase.
  reg timer_clock_select_r;
  wire [NUM_SRC-1:0] src_tick;
  wire tick;

  genvar g;
  generate
    for (g = 0; g < NUM_SRC; g = g + 1) begin : g_src
      localparam [31:0] RATE = (g == SRC_LP) ? LP_TICK_HZ : RC_TICK_HZ;
      reg [31:0] phase_r;
      reg [31:0] phase_nxt;
      reg tick_r;
      reg tick_nxt;

      always @* begin
        phase_nxt = phase_r + RATE;
        tick_nxt = 1'b0;
        if (phase_nxt >= MCLK_RATE) begin
          phase_nxt = phase_nxt - MCLK_RATE;
          tick_nxt = 1'b1;
        end
      end

      always @(posedge i_mclk or negedge i_resetn) begin
        if (!i_resetn) begin
          phase_r <= 32'h00000000;
          tick_r <= 1'b0;
        end else if (i_ce) begin
          phase_r <= phase_nxt;
          tick_r <= tick_nxt;
        end
      end

      assign src_tick[g] = tick_r;
    end
  endgenerate

  assign tick = timer_clock_select_r ? src_tick[SRC_LP]
                         : src_tick[SRC_RC];

  // ************************************************************
  // Register decode
  // ************************************************************
  wire wr_ctrl;
  wire wr_count;
  wire wr_stat;
  wire wr_mask;
  wire clear_req;
  wire alarm_w1c;
  assign wr_ctrl = i_wr && (i_addr == `SWT_OFS_CTRL);
  assign wr_count = i_wr && (i_addr == `SWT_OFS_COUNT);
  assign wr_stat = i_wr && (i_addr == `SWT_OFS_IRQ_STAT);
  assign wr_mask = i_wr && (i_addr == `SWT_OFS_IRQ_MASK);
  // A zero in either bit is a no-op by construction
  assign clear_req = wr_ctrl && i_wdata[`SWT_CTRL_CLEAR];
  assign alarm_w1c = (wr_ctrl || wr_stat)
                     && i_wdata[`SWT_CTRL_ALARM];

  // ************************************************************
  // Run state
  // ************************************************************
  reg state_r;
  reg state_nxt;
  reg [31:0] count_r;
  reg [31:0] count_nxt;
  wire timeout;
  // Time-out is the tick that takes the counter from one to zero
  assign timeout = (state_r == ST_RUN) && tick && (count_r == CNT_ONE);

  always @* begin
    state_nxt = state_r;
    case (state_r)
      ST_IDLE: begin
        if (wr_count && (i_wdata != CNT_ZERO)) begin
          state_nxt = ST_RUN;
        end
      end
      ST_RUN: begin
        if (wr_count) begin
          // A load while running is a software fault; nonzero restarts, zero stops
          if (i_wdata == CNT_ZERO) begin
            state_nxt = ST_IDLE;
          end
        end else if (tick && (count_r == CNT_ONE)) begin
          state_nxt = ST_IDLE;
        end
      end
      default: begin
        state_nxt = ST_IDLE;
      end
    endcase
    // Clear wins over a load or tick in the same cycle
    if (clear_req) begin
      state_nxt = ST_IDLE;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      state_r <= ST_IDLE;
    end else if (i_ce) begin
      state_r <= state_nxt;
    end
  end

  // ************************************************************
  // Counter
  // ************************************************************
  // Idle holds the count, zero after a time-out: no auto reload
  always @* begin
    count_nxt = count_r;
    if (clear_req) begin
      count_nxt = CNT_ZERO;
    end else if (wr_count) begin
      count_nxt = i_wdata;
    end else if ((state_r == ST_RUN) && tick) begin
      count_nxt = count_r - CNT_ONE;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      count_r <= `SWT_COUNT_RESET;
    end else if (i_ce) begin
      count_r <= count_nxt;
    end
  end

  // ************************************************************
  // Clock select
  // ************************************************************
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      timer_clock_select_r <= `SWT_TIMER_CLOCK_SELECT_RESET;
    end else if (i_ce && wr_ctrl) begin
      timer_clock_select_r <= i_wdata[`SWT_CTRL_TIMER_CLOCK_SELECT];
    end
  end

  // ************************************************************
  // Alarm flag
  // ************************************************************
  reg alarm_r;
  reg alarm_nxt;

  always @* begin
    alarm_nxt = alarm_r;
    // A time-out in the clearing cycle wins over the clear
    if (timeout) begin
      alarm_nxt = 1'b1;
    end else if (alarm_w1c) begin
      alarm_nxt = 1'b0;
    end
  end

  // Loads and counter clears leave the flag alone, so a wake-up
  // that software has not yet seen is never lost
  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      alarm_r <= 1'b0;
    end else if (i_ce) begin
      alarm_r <= alarm_nxt;
    end
  end

  // ************************************************************
  // Interrupt mask
  // ************************************************************
  reg mask_r;

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      mask_r <= `SWT_MASK_RESET;
    end else if (i_ce && wr_mask) begin
      mask_r <= i_wdata[`SWT_CTRL_ALARM];
    end
  end

  // ************************************************************
  // Read data
  // ************************************************************
  reg [31:0] rdata_nxt;

  always @* begin
    rdata_nxt = 32'h00000000;
    case (i_addr)
      `SWT_OFS_CTRL: begin
        // Clear bit is never stored, so it reads zero
        rdata_nxt[`SWT_CTRL_TIMER_CLOCK_SELECT] = timer_clock_select_r;
        rdata_nxt[`SWT_CTRL_ALARM] = alarm_r;
        rdata_nxt[`SWT_CTRL_CLEAR] = 1'b0;
      end
      `SWT_OFS_COUNT: begin
        // Live value: no snapshot, software must cope
        rdata_nxt = count_r;
      end
      `SWT_OFS_IRQ_STAT: begin
        rdata_nxt[`SWT_CTRL_ALARM] = alarm_r;
      end
      `SWT_OFS_IRQ_MASK: begin
        rdata_nxt[`SWT_CTRL_ALARM] = mask_r;
      end
      default: begin
        rdata_nxt = 32'h00000000;
      end
    endcase
  end

  // ************************************************************
  // Outputs
  // ************************************************************
  // Every output is registered, so each trails its source by a cycle
  wire irq_nxt;
  wire wake_nxt;
  wire running_nxt;
  assign irq_nxt = alarm_r && mask_r;
  // Wake request is unmasked so it works in any power mode
  assign wake_nxt = alarm_r;
  assign running_nxt = (state_r == ST_RUN);

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 32'h00000000;
    end else if (i_ce) begin
      // Read data stands for one cycle only, zero otherwise
      o_rdata <= i_rd ? rdata_nxt : 32'h00000000;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_irq <= 1'b0;
    end else if (i_ce) begin
      o_irq <= irq_nxt;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_wake_req <= 1'b0;
    end else if (i_ce) begin
      o_wake_req <= wake_nxt;
    end
  end

  always @(posedge i_mclk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_running <= 1'b0;
    end else if (i_ce) begin
      o_running <= running_nxt;
    end
  end

endmodule
`default_nettype wire

/* tb_self_wakeup_down_counter.sv */
// Self-checking bench for the self wake-up timer.
// Drives the register port directly; short tick dividers.
`timescale 1ns/1ns
`default_nettype none
module tb_self_wakeup_down_counter;
  logic i_mclk = 0, i_resetn = 0, i_ce = 1, i_wr = 0, i_rd = 0, pend = 0;
  logic [7:0] i_addr = 8'h00;
  logic [31:0] i_wdata = 32'h0, o_rdata, q[$], n, cnt;
  logic o_irq, o_wake_req, o_running;
  int miscompares = 0, n_checks = 0, d;
  always #20 i_mclk = ~i_mclk;
  swt_self_wake_timer #(.MCLK_HZ(40), .RC_TICK_HZ(10), .LP_TICK_HZ(5))
    u_dut (.i_mclk(i_mclk),
    .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
    .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
    .o_wake_req(o_wake_req), .o_running(o_running));
  task chk(input [31:0] s, input [31:0] e);
    n_checks++;
    if (s !== e) begin
      miscompares++;
      $display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
    end
  endtask
  // A read notes its expected word; the monitor below compares it
  task acc(input w, input [7:0] a, input [31:0] v);
    @(posedge i_mclk);
    i_addr <= a;
    i_wdata <= v;
    i_wr <= w;
    i_rd <= !w;
    if (!w) q.push_back(v);
    @(posedge i_mclk);
    i_wr <= 0;
    i_rd <= 0;
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(negedge i_mclk) begin
    if (pend) chk(o_rdata, q.pop_front());
    pend = i_rd;
  end
  // Far above the expected run of at most about two hundred cycles
  initial begin
    #400000;
    miscompares++;
    wrap_up;
  end
  initial begin
    n = $urandom(32'h7b7ea690);
    repeat (8) @(posedge i_mclk);
    i_resetn <= 1;
    acc(0, 8'h00, 32'h0);
    acc(0, 8'h14, 32'h0);
    acc(0, 8'h24, 32'h0);
    for (int s = 0; s < 2; s++) begin
      n = $urandom % 8 + 2;
      d = s ? 8 : 4;
      acc(1, 8'h00, s);
      acc(1, 8'h0c, n);
      repeat (2) @(negedge i_mclk);
      cnt = 0;
      while (o_running === 1'b1 && cnt < 999) begin
        @(negedge i_mclk);
        cnt++;
      end
      chk({31'h0, cnt > (n - 1) * d && cnt <= n * d + 1}, 1);
      chk(o_wake_req, 1);
      chk(o_irq, 0);
      acc(0, 8'h00, 2 | s);
      acc(0, 8'h0c, 32'h0);
      acc(0, 8'h0c, 32'h0);
      acc(1, 8'h00, s);
      acc(0, 8'h00, 2 | s);
      acc(1, 8'h14, 32'h2);
      repeat (2) @(negedge i_mclk);
      chk(o_irq, 1);
      acc(1, 8'h00, 2 | s);
      acc(0, 8'h00, s);
      acc(1, 8'h14, 32'h0);
      $display("test %0d done", s);
    end
    acc(1, 8'h0c, 32'h100);
    acc(1, 8'h00, 32'h4);
    acc(0, 8'h00, 32'h0);
    acc(0, 8'h0c, 32'h0);
    repeat (2) @(negedge i_mclk);
    chk(o_running, 0);
    $display("test 2 done");
    wrap_up;
  end
endmodule
bind swt_self_wake_timer swt_checker u_chk (.i_mclk(i_mclk),
  .i_resetn(i_resetn), .i_ce(i_ce), .i_addr(i_addr), .i_wdata(i_wdata),
  .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_irq(o_irq),
  .o_wake_req(o_wake_req), .o_running(o_running));
`default_nettype wire
